// ---- logic/core_message_mailboxes.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - outside write into inbound queue adds one to count while under four
// R2 - core read of inbound queue removes one entry, count minus one
// R3 - inbound queue is first-in first-out; reads return oldest message
// R4 - write to full inbound queue keeps count four, overwrites newest slot
// R5 - core write to full outbound mailbox stalls until outside read empties it
// R6 - core read of empty inbound queue stalls; count queries never stall
// R7 - blocking channel with zero count holds core until count nonzero
// R8 - outside writes into inbound queue always complete, never back-pressured
// R9 - outside outbound reads or inbound writes raise enabled core events
// R10 - core write to free plain mailbox stores value, count drops by one
// R11 - full plain outbound mailbox reads count zero to the core
// R12 - outside read of plain mailbox returns message, count up by one
// R13 - interrupting mailbox accepting core write drops count, raises host interrupt
// R14 - host interrupt need not be ordered with earlier transfer commands
// R15 - host fetches interrupting message by read; count rises by one
// R16 - full interrupting mailbox reads count zero; core write stalls until drained
// R17 - every mailbox entry carries a 32-bit message
// R18 - exactly two one-entry outbound mailboxes: plain and interrupting
// R19 - core write to outbound mailbox with space completes at once
// R20 - read-only status register reports mailbox entry counts
// R21 - outside reader checks status count before reading outbound mailbox
// R22 - after reset, all empty: inbound count zero, outbound counts one
module core_message_mailboxes #(
  parameter int WIDTH = mbox_pkg::MSG_W,
  parameter int DEPTH = mbox_pkg::IN_DEPTH
) (
  input  wire logic                     mclk_in,
  input  wire logic                     reset_n_in,
  // core channel side
  input  wire logic                     ch_req_in,
  input  wire logic                     ch_write_in,
  input  wire mbox_pkg::chan_t          ch_sel_in,
  input  wire logic [WIDTH-1:0]         ch_wdata_in,
  output logic                          ch_done_out,
  output logic                          ch_stall_out,
  output logic      [WIDTH-1:0]         ch_rdata_out,
  // channel-count query, always answered
  input  wire mbox_pkg::chan_t          cnt_sel_in,
  output logic      [mbox_pkg::CNT_W-1:0] cnt_value_out,
  // outside memory-mapped side
  input  wire logic                     mm_in_wr_in,
  input  wire logic [WIDTH-1:0]         mm_in_wdata_in,
  input  wire logic                     mm_out_rd_in,
  input  wire logic                     mm_intr_rd_in,
  input  wire logic                     mm_stat_rd_in,
  output logic                          mm_rvalid_out,
  output logic      [WIDTH-1:0]         mm_rdata_out,
  // event and interrupt controls
  input  wire logic [2:0]               event_en_in,
  input  wire logic                     host_irq_en_in,
  output logic                          core_event_out,
  output logic                          host_irq_out
);
  initial begin
    if (WIDTH != mbox_pkg::MSG_W) $error("message width must be 32");
    if (DEPTH < 1 || DEPTH > 7) $error("inbound depth unsupported");
  end

  // event bit positions in event_en_in
  localparam int EV_IN_WR  = 0;
  localparam int EV_OUT_RD = 1;
  localparam int EV_INT_RD = 2;

  typedef struct packed {
    mbox_pkg::core_state_t state;
    logic                  wr;
    mbox_pkg::chan_t       sel;
    logic [WIDTH-1:0]      wdata;
    logic                  done;
    logic                  stall;
    logic [WIDTH-1:0]      rdata;
    logic [mbox_pkg::CNT_W-1:0] cnt;
    logic                  rvalid;
    logic [WIDTH-1:0]      mrdata;
    logic                  event_p;
    logic                  irq;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;

  logic [WIDTH-1:0]           in_head;
  logic [mbox_pkg::CNT_W-1:0] in_count;
  logic                       in_pop;
  logic [WIDTH-1:0]           out_data;
  logic                       out_full;
  logic                       out_load;
  logic [WIDTH-1:0]           int_data;
  logic                       int_full;
  logic                       int_load;
  logic                       act_wr;
  mbox_pkg::chan_t            act_sel;
  logic [WIDTH-1:0]           act_wdata;
  logic                       act_valid;
  logic                       can_go;
  logic [mbox_pkg::CNT_W-1:0] out_free;
  logic [mbox_pkg::CNT_W-1:0] int_free;

  // outbound free counts: one when empty, zero when full
  assign out_free = out_full ? '0 : mbox_pkg::CNT_W'(mbox_pkg::OUT_DEPTH); // R11
  assign int_free = int_full ? '0 : mbox_pkg::CNT_W'(mbox_pkg::OUT_DEPTH); // R16

  // active request: a held stalled one wins over a new one
  always_comb begin
    if (st_ff.state == mbox_pkg::ST_STALL) begin
      act_valid = 1'b1;
      act_wr    = st_ff.wr;
      act_sel   = st_ff.sel;
      act_wdata = st_ff.wdata;
    end else begin
      act_valid = ch_req_in && (ch_sel_in != mbox_pkg::CH_NONE);
      act_wr    = ch_write_in;
      act_sel   = ch_sel_in;
      act_wdata = ch_wdata_in;
    end
  end

  // a blocking access proceeds only when its channel count is nonzero
  always_comb begin
    case (act_sel)
      mbox_pkg::CH_IN:        can_go = !act_wr && (in_count != '0); // R6
      mbox_pkg::CH_OUT_PLAIN: can_go = act_wr && !out_full; // R19
      mbox_pkg::CH_OUT_INTR:  can_go = act_wr && !int_full; // R19
      default:                can_go = 1'b0;
    endcase
  end

  assign in_pop   = act_valid && can_go && (act_sel == mbox_pkg::CH_IN); // R2
  assign out_load = act_valid && can_go && (act_sel == mbox_pkg::CH_OUT_PLAIN); // R10
  assign int_load = act_valid && can_go && (act_sel == mbox_pkg::CH_OUT_INTR); // R13

  // one queue, two single-entry mailboxes
  inbound_queue #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_inq (
    .mclk_in      (mclk_in),
    .reset_n_in   (reset_n_in),
    .push_in      (mm_in_wr_in), // R8
    .push_data_in (mm_in_wdata_in),
    .pop_in       (in_pop),
    .head_out     (in_head),
    .count_out    (in_count)
  );

  outbound_slot #(
    .WIDTH (WIDTH)
  ) u_out_plain ( // R18
    .mclk_in      (mclk_in),
    .reset_n_in   (reset_n_in),
    .load_in      (out_load),
    .load_data_in (act_wdata),
    .drain_in     (mm_out_rd_in), // R12
    .data_out     (out_data),
    .full_out     (out_full)
  );

  outbound_slot #(
    .WIDTH (WIDTH)
  ) u_out_intr ( // R18
    .mclk_in      (mclk_in),
    .reset_n_in   (reset_n_in),
    .load_in      (int_load),
    .load_data_in (act_wdata),
    .drain_in     (mm_intr_rd_in), // R15
    .data_out     (int_data),
    .full_out     (int_full)
  );

  // core engine, outside read mux, events and interrupt
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.done    = 1'b0;
    nxt_st.event_p = 1'b0;
    nxt_st.irq     = 1'b0;
    nxt_st.rvalid  = 1'b0;
    case (st_ff.state)
      mbox_pkg::ST_IDLE: begin
        if (act_valid && can_go) begin
          nxt_st.done = 1'b1;
        end else if (act_valid) begin
          nxt_st.state = mbox_pkg::ST_STALL; // R7
          nxt_st.wr    = act_wr;
          nxt_st.sel   = act_sel;
          nxt_st.wdata = act_wdata;
        end
      end
      mbox_pkg::ST_STALL: begin
        if (can_go) begin
          nxt_st.state = mbox_pkg::ST_IDLE; // R5
          nxt_st.done  = 1'b1;
        end
      end
      default: nxt_st.state = mbox_pkg::ST_IDLE;
    endcase
    nxt_st.stall = (nxt_st.state == mbox_pkg::ST_STALL);
    if (in_pop) begin
      nxt_st.rdata = in_head; // R3
    end
    // count query never stalls
    case (cnt_sel_in)
      mbox_pkg::CH_IN:        nxt_st.cnt = in_count; // R6
      mbox_pkg::CH_OUT_PLAIN: nxt_st.cnt = out_free; // R11
      mbox_pkg::CH_OUT_INTR:  nxt_st.cnt = int_free; // R16
      default:                nxt_st.cnt = '0;
    endcase
    // irq is ungated by transfer ordering; it follows the accept, when host_irq_en_in is set, only
    nxt_st.irq = int_load && host_irq_en_in; // R13 R14
    nxt_st.event_p = (mm_in_wr_in && event_en_in[EV_IN_WR]) ||
                     (mm_out_rd_in && event_en_in[EV_OUT_RD]) ||
                     (mm_intr_rd_in && event_en_in[EV_INT_RD]); // R9
    // outside reads; empty mailbox read returns stale data
    if (mm_out_rd_in) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.mrdata = out_data; // R12
    end else if (mm_intr_rd_in) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.mrdata = int_data; // R15
    end else if (mm_stat_rd_in) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.mrdata = '0;
      nxt_st.mrdata[mbox_pkg::STAT_IN_LSB +: mbox_pkg::STAT_FLD_W] =
        mbox_pkg::STAT_FLD_W'(in_count); // R20
      nxt_st.mrdata[mbox_pkg::STAT_OUT_LSB +: mbox_pkg::STAT_FLD_W] =
        mbox_pkg::STAT_FLD_W'(out_free); // R20
      nxt_st.mrdata[mbox_pkg::STAT_INT_LSB +: mbox_pkg::STAT_FLD_W] =
        mbox_pkg::STAT_FLD_W'(int_free); // R20
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff       <= '0;
      st_ff.state <= mbox_pkg::ST_IDLE;
      st_ff.sel   <= mbox_pkg::CH_NONE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ch_done_out    = st_ff.done;
  assign ch_stall_out   = st_ff.stall;
  assign ch_rdata_out   = st_ff.rdata;
  assign cnt_value_out  = st_ff.cnt;
  assign mm_rvalid_out  = st_ff.rvalid;
  assign mm_rdata_out   = st_ff.mrdata;
  assign core_event_out = st_ff.event_p;
  assign host_irq_out   = st_ff.irq;

  // checks
  sequence s_in_write_full;
    mm_in_wr_in && (in_count == mbox_pkg::CNT_W'(DEPTH)) && !in_pop;
  endsequence

  property p_in_count_up;
    @(posedge mclk_in) disable iff (!reset_n_in)
      mm_in_wr_in && !in_pop && in_count < mbox_pkg::CNT_W'(DEPTH) |=> in_count == $past(in_count) + 1'b1;
  endproperty
  a_in_count_up: assert property (p_in_count_up) else $error("inbound count did not rise"); // R1

  property p_in_count_down;
    @(posedge mclk_in) disable iff (!reset_n_in)
      in_pop && !mm_in_wr_in |=> in_count == $past(in_count) - 1'b1;
  endproperty
  a_in_count_down: assert property (p_in_count_down) else $error("inbound count did not fall"); // R2

  property p_in_full_hold;
    @(posedge mclk_in) disable iff (!reset_n_in)
      s_in_write_full |=> in_count == mbox_pkg::CNT_W'(DEPTH);
  endproperty
  a_in_full_hold: assert property (p_in_full_hold) else $error("full inbound count moved"); // R4

  property p_pop_data;
    @(posedge mclk_in) disable iff (!reset_n_in)
      in_pop |=> ch_done_out && ch_rdata_out == $past(in_head);
  endproperty
  a_pop_data: assert property (p_pop_data) else $error("core read not oldest entry"); // R3

  property p_full_write_stalls;
    @(posedge mclk_in) disable iff (!reset_n_in)
      ch_req_in && ch_write_in && st_ff.state == mbox_pkg::ST_IDLE &&
      ch_sel_in == mbox_pkg::CH_OUT_PLAIN && out_full && !mm_out_rd_in |=> ch_stall_out && !ch_done_out;
  endproperty
  a_full_write_stalls: assert property (p_full_write_stalls) else $error("write to full mailbox not stalled"); // R5

  property p_stall_release;
    @(posedge mclk_in) disable iff (!reset_n_in)
      ch_stall_out && can_go |=> ch_done_out && !ch_stall_out;
  endproperty
  a_stall_release: assert property (p_stall_release) else $error("stall not released"); // R7

  property p_free_write_done;
    @(posedge mclk_in) disable iff (!reset_n_in)
      out_load |=> ch_done_out ##0 out_full ##0 out_free == '0;
  endproperty
  a_free_write_done: assert property (p_free_write_done) else $error("free write not done at once"); // R10

  property p_drain_count;
    @(posedge mclk_in) disable iff (!reset_n_in)
      mm_intr_rd_in && !int_load |=> int_free == mbox_pkg::CNT_W'(mbox_pkg::OUT_DEPTH) && mm_rvalid_out;
  endproperty
  a_drain_count: assert property (p_drain_count) else $error("drain did not free mailbox"); // R15

  property p_irq;
    @(posedge mclk_in) disable iff (!reset_n_in)
      host_irq_out |-> $past(int_load) && $past(host_irq_en_in);
  endproperty
  a_irq: assert property (p_irq) else $error("host interrupt without accept"); // R13

  property p_event;
    @(posedge mclk_in) disable iff (!reset_n_in)
      mm_out_rd_in && event_en_in[EV_OUT_RD] |=> core_event_out;
  endproperty
  a_event: assert property (p_event) else $error("enabled event not raised"); // R9

  property p_irq_on_accept;
    @(posedge mclk_in) disable iff (!reset_n_in)
      int_load && host_irq_en_in |=> host_irq_out;
  endproperty
  a_irq_on_accept: assert property (p_irq_on_accept) else $error("accept raised no interrupt"); // R13

  property p_plain_full_cnt;
    @(posedge mclk_in) disable iff (!reset_n_in)
      cnt_sel_in == mbox_pkg::CH_OUT_PLAIN && out_full |=> cnt_value_out == '0;
  endproperty
  a_plain_full_cnt: assert property (p_plain_full_cnt) else $error("full plain count not zero"); // R11

  property p_intr_full_cnt;
    @(posedge mclk_in) disable iff (!reset_n_in)
      cnt_sel_in == mbox_pkg::CH_OUT_INTR && int_full |=> cnt_value_out == '0;
  endproperty
  a_intr_full_cnt: assert property (p_intr_full_cnt) else $error("full intr count not zero"); // R16

  property p_in_cnt_query;
    @(posedge mclk_in) disable iff (!reset_n_in)
      cnt_sel_in == mbox_pkg::CH_IN |=> cnt_value_out == $past(in_count);
  endproperty
  a_in_cnt_query: assert property (p_in_cnt_query) else $error("inbound count query wrong"); // R6

  property p_out_read_data;
    @(posedge mclk_in) disable iff (!reset_n_in)
      mm_out_rd_in |=> mm_rvalid_out && mm_rdata_out == $past(out_data);
  endproperty
  a_out_read_data: assert property (p_out_read_data) else $error("plain read data wrong"); // R12

  property p_in_event;
    @(posedge mclk_in) disable iff (!reset_n_in)
      mm_in_wr_in && event_en_in[EV_IN_WR] |=> core_event_out;
  endproperty
  a_in_event: assert property (p_in_event) else $error("inbound write event not raised"); // R9
endmodule : core_message_mailboxes // core_message_mailboxes
`default_nettype wire

// ---- logic/mbox_pkg.sv ----
package mbox_pkg;
  // message width and queue depths
  localparam int MSG_W        = 32;
  localparam int IN_DEPTH     = 4;
  localparam int OUT_DEPTH    = 1;
  localparam int CNT_W        = 3;
  // status word layout: inbound count, plain outbound free, interrupting outbound free
  localparam int STAT_IN_LSB  = 0;
  localparam int STAT_OUT_LSB = 8;
  localparam int STAT_INT_LSB = 16;
  localparam int STAT_FLD_W   = 8;
  // offset of the status register in the outside map
  localparam logic [19:0] STAT_OFFSET = 20'h0_4014;
  // core channel selectors
  typedef enum logic [1:0] {
    CH_NONE,
    CH_OUT_PLAIN,
    CH_IN,
    CH_OUT_INTR
  } chan_t;
  // core access engine states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_STALL
  } core_state_t;
endpackage : mbox_pkg

// ---- logic/inbound_queue.sv ----
`timescale 1ns/1ps
`default_nettype none
// four-deep inbound queue; a push when full overwrites the newest slot
module inbound_queue #(
  parameter int WIDTH = mbox_pkg::MSG_W,
  parameter int DEPTH = mbox_pkg::IN_DEPTH
) (
  input  wire logic                 mclk_in,
  input  wire logic                 reset_n_in,
  input  wire logic                 push_in,
  input  wire logic [WIDTH-1:0]     push_data_in,
  input  wire logic                 pop_in,
  output logic      [WIDTH-1:0]     head_out,
  output logic      [mbox_pkg::CNT_W-1:0] count_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 1 || DEPTH > 7) $error("inbound_queue depth unsupported");
  end

  typedef struct packed {
    logic [AW-1:0]              rd_ptr;
    logic [mbox_pkg::CNT_W-1:0] count;
  } q_state_t;

  q_state_t          st_ff;
  q_state_t          nxt_st;
  logic [WIDTH-1:0]  mem_ff [DEPTH];
  logic [AW-1:0]     wr_idx;
  logic              do_pop;

  // write slot: the next free one, or the newest when full
  always_comb begin
    nxt_st = st_ff;
    do_pop = pop_in && (st_ff.count != '0);
    // a pop in the same cycle frees the head slot, so nothing is overwritten then
    if (st_ff.count == mbox_pkg::CNT_W'(DEPTH) && !do_pop) begin
      wr_idx = AW'((32'(st_ff.rd_ptr) + DEPTH - 1) % DEPTH); // R4
    end else begin
      wr_idx = AW'((32'(st_ff.rd_ptr) + 32'(st_ff.count)) % DEPTH);
    end
    if (do_pop) begin
      nxt_st.rd_ptr = AW'((32'(st_ff.rd_ptr) + 1) % DEPTH); // R3
    end
    // count holds on overwrite, moves only on net change
    if (push_in && !do_pop && st_ff.count != mbox_pkg::CNT_W'(DEPTH)) begin
      nxt_st.count = st_ff.count + 1'b1; // R1
    end else if (do_pop && !push_in) begin
      nxt_st.count = st_ff.count - 1'b1; // R2
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff <= '0; // R22
    end else begin
      st_ff <= nxt_st;
    end
  end

  // storage has no reset; count guards validity
  always_ff @(posedge mclk_in) begin
    if (push_in) begin
      mem_ff[wr_idx] <= push_data_in;
    end
  end

  assign head_out  = mem_ff[st_ff.rd_ptr]; // R3
  assign count_out = st_ff.count;
endmodule : inbound_queue // inbound_queue
`default_nettype wire

// ---- logic/outbound_slot.sv ----
`timescale 1ns/1ps
`default_nettype none
// one-entry outbound mailbox; free count is 1 when empty, 0 when full
module outbound_slot #(
  parameter int WIDTH = mbox_pkg::MSG_W
) (
  input  wire logic             mclk_in,
  input  wire logic             reset_n_in,
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] load_data_in,
  input  wire logic             drain_in,
  output logic      [WIDTH-1:0] data_out,
  output logic                  full_out
);
  typedef struct packed {
    logic             full;
    logic [WIDTH-1:0] data;
  } s_state_t;

  s_state_t st_ff;
  s_state_t nxt_st;

  // load only into an empty slot; drain frees it
  always_comb begin
    nxt_st = st_ff;
    if (drain_in) begin
      nxt_st.full = 1'b0; // R12
    end
    if (load_in && !st_ff.full) begin
      nxt_st.full = 1'b1; // R10
      nxt_st.data = load_data_in; // R17
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff <= '0; // R22
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign data_out = st_ff.data;
  assign full_out = st_ff.full;
endmodule : outbound_slot // outbound_slot
`default_nettype wire

// ---- bench/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// outside party: strobes change just after the falling edge, one cycle each
module host_model (
  input  wire logic        mclk_in,
  output logic             mm_in_wr_out,
  output logic [31:0]      mm_in_wdata_out,
  output logic             mm_out_rd_out,
  output logic             mm_intr_rd_out,
  output logic             mm_stat_rd_out,
  input  wire logic        mm_rvalid_in,
  input  wire logic [31:0] mm_rdata_in
);
  initial begin
    mm_in_wr_out = 1'b0;
    mm_in_wdata_out = 32'h0000_0000;
    mm_out_rd_out = 1'b0;
    mm_intr_rd_out = 1'b0;
    mm_stat_rd_out = 1'b0;
  end
  // writes never wait for an answer, full queue or not
  task automatic push(input logic [31:0] d);
    @(negedge mclk_in);
    mm_in_wr_out = 1'b1;
    mm_in_wdata_out = d;
    @(negedge mclk_in);
    mm_in_wr_out = 1'b0;
    mm_in_wdata_out = ~d; // released bus must not keep the old value
  endtask
  // which: 0 plain, 1 interrupting, 2 status; bounded wait for the answer
  task automatic fetch(input int which, output logic [31:0] d, output bit ok);
    int i;
    @(negedge mclk_in);
    mm_out_rd_out = (which == 0);
    mm_intr_rd_out = (which == 1);
    mm_stat_rd_out = (which == 2);
    @(negedge mclk_in);
    mm_out_rd_out = 1'b0;
    mm_intr_rd_out = 1'b0;
    mm_stat_rd_out = 1'b0;
    ok = 1'b0;
    d = 32'h0000_0000;
    for (i = 0; i < 4; i++) begin
      if (mm_rvalid_in === 1'b1) begin
        ok = 1'b1;
        d = mm_rdata_in;
        break;
      end
      @(negedge mclk_in);
    end
  endtask
  // mailbox read only after status shows unread data (free field zero)
  task automatic take_mail(input int which, output logic [31:0] d, output bit ok);
    logic [31:0] st;
    fetch(2, st, ok);
    if (ok && st[8+8*which +: 8] == 8'h00) begin
      fetch(which, d, ok);
    end else begin
      ok = 1'b0;
    end
  endtask
endmodule // host_model
`default_nettype wire

// ---- bench/core_message_mailboxes_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module core_message_mailboxes_test;
  logic             mclk_in = 1'b0;
  logic             reset_n_in = 1'b0;
  logic             ch_req = 1'b0;
  logic             ch_write = 1'b0;
  mbox_pkg::chan_t  ch_sel = mbox_pkg::CH_NONE;
  logic [31:0]      ch_wdata = 32'h0000_0000;
  mbox_pkg::chan_t  cnt_sel = mbox_pkg::CH_NONE;
  logic [2:0]       event_en = 3'b000;
  logic             host_irq_en = 1'b0;
  logic             ch_done_out, ch_stall_out, mm_rvalid_out, core_event_out, host_irq_out;
  logic [31:0]      ch_rdata_out, mm_rdata_out, mm_in_wdata;
  logic [2:0]       cnt_value_out;
  logic             mm_in_wr, mm_out_rd, mm_intr_rd, mm_stat_rd;
  int               n_errors = 0;
  int               total_checks = 0;
  int               ev_cnt = 0;
  int               irq_cnt = 0;

  always #2 mclk_in = ~mclk_in;

  core_message_mailboxes dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .ch_req_in(ch_req),
    .ch_write_in(ch_write), .ch_sel_in(ch_sel), .ch_wdata_in(ch_wdata), .ch_done_out(ch_done_out),
    .ch_stall_out(ch_stall_out), .ch_rdata_out(ch_rdata_out), .cnt_sel_in(cnt_sel),
    .cnt_value_out(cnt_value_out), .mm_in_wr_in(mm_in_wr), .mm_in_wdata_in(mm_in_wdata),
    .mm_out_rd_in(mm_out_rd), .mm_intr_rd_in(mm_intr_rd), .mm_stat_rd_in(mm_stat_rd),
    .mm_rvalid_out(mm_rvalid_out), .mm_rdata_out(mm_rdata_out), .event_en_in(event_en),
    .host_irq_en_in(host_irq_en), .core_event_out(core_event_out), .host_irq_out(host_irq_out));

  host_model host (.mclk_in(mclk_in), .mm_in_wr_out(mm_in_wr), .mm_in_wdata_out(mm_in_wdata),
    .mm_out_rd_out(mm_out_rd), .mm_intr_rd_out(mm_intr_rd), .mm_stat_rd_out(mm_stat_rd),
    .mm_rvalid_in(mm_rvalid_out), .mm_rdata_in(mm_rdata_out));

  // pulse counters, sampled mid-cycle where registered outputs are settled
  always @(negedge mclk_in) begin
    if (core_event_out === 1'b1) ev_cnt++;
    if (host_irq_out === 1'b1) irq_cnt++;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // count answer is registered, so give it two edges
  task automatic query(input mbox_pkg::chan_t c, input logic [2:0] exp, input string what);
    @(negedge mclk_in);
    cnt_sel = c;
    @(negedge mclk_in);
    @(negedge mclk_in);
    chk(what, {29'h0, cnt_value_out}, {29'h0, exp});
  endtask

  // request is sampled only while idle, so one cycle is enough and avoids a retake
  task automatic core_go(input logic wr, input mbox_pkg::chan_t c, input logic [31:0] d);
    @(negedge mclk_in);
    ch_req = 1'b1;
    ch_write = wr;
    ch_sel = c;
    ch_wdata = d;
    @(negedge mclk_in);
    ch_req = 1'b0;
    ch_sel = mbox_pkg::CH_NONE;
  endtask

  task automatic core_wait(input int lim, output int took);
    took = 0;
    while (ch_done_out !== 1'b1) begin
      if (took >= lim) begin
        n_errors++;
        $display("BAD core done expected 1 seen 0");
        wrap_up();
      end
      @(negedge mclk_in);
      took++;
    end
  endtask

  task automatic do_reset();
    @(negedge mclk_in);
    reset_n_in = 1'b0;
    repeat (10) @(negedge mclk_in);
    reset_n_in = 1'b1;
  endtask

  // empty after reset: inbound 0, each outbound one free slot
  task automatic t_reset();
    logic [31:0] st;
    bit ok;
    chk("irq idle", {31'h0, host_irq_out}, 32'h0000_0000);
    query(mbox_pkg::CH_IN, 3'h0, "in count");
    query(mbox_pkg::CH_OUT_PLAIN, 3'h1, "plain free");
    query(mbox_pkg::CH_OUT_INTR, 3'h1, "intr free");
    host.fetch(2, st, ok);
    chk("status", ok ? st : 32'hFFFF_FFFF, 32'h0001_0100);
  endtask

  // five writes into four slots: fourth message is lost, count sticks at four
  task automatic t_inbound();
    int ev0, took, k;
    int order[4] = '{0, 1, 2, 4};
    logic [31:0] st;
    bit ok;
    event_en = 3'b001;
    ev0 = ev_cnt;
    for (k = 0; k < 5; k++) begin
      host.push(32'hA5A5_0000 + k);
      query(mbox_pkg::CH_IN, (k < 4) ? 3'(k + 1) : 3'h4, "in count up");
    end
    chk("in events", ev_cnt - ev0, 5);
    host.fetch(2, st, ok);
    chk("status in", ok ? st : 32'hFFFF_FFFF, 32'h0001_0104);
    for (k = 0; k < 4; k++) begin
      core_go(1'b0, mbox_pkg::CH_IN, 32'h0000_0000);
      core_wait(3, took);
      query(mbox_pkg::CH_IN, 3'(3 - k), "in count down");
      chk("in data", ch_rdata_out, 32'hA5A5_0000 + order[k]);
    end
  endtask

  // read of an empty queue stalls; the count query keeps answering
  task automatic t_stall_read();
    int ev0, took;
    event_en = 3'b000;
    ev0 = ev_cnt;
    core_go(1'b0, mbox_pkg::CH_IN, 32'h0000_0000);
    repeat (3) @(negedge mclk_in);
    chk("read stall", {31'h0, ch_stall_out}, 32'h0000_0001);
    query(mbox_pkg::CH_IN, 3'h0, "count in stall");
    host.push(32'h8000_0001);
    core_wait(6, took);
    @(negedge mclk_in);
    chk("late data", ch_rdata_out, 32'h8000_0001);
    chk("masked event", ev_cnt - ev0, 0);
  endtask

  // which: 0 plain, 1 interrupting; only the interrupting one reaches the host
  task automatic t_outbound(input int which);
    mbox_pkg::chan_t c;
    int ev0, irq0, took;
    logic [31:0] d;
    bit ok;
    c = (which == 1) ? mbox_pkg::CH_OUT_INTR : mbox_pkg::CH_OUT_PLAIN;
    event_en = 3'b110;
    host_irq_en = 1'b1;
    ev0 = ev_cnt;
    irq0 = irq_cnt;
    core_go(1'b1, c, 32'hC0DE_0000 + which);
    core_wait(2, took);
    chk("no stall", took <= 1, 32'h0000_0001);
    query(c, 3'h0, "full count");
    chk("irq once", irq_cnt - irq0, which);
    core_go(1'b1, c, 32'hFEED_0000 + which);
    repeat (3) @(negedge mclk_in);
    chk("write stall", {31'h0, ch_stall_out}, 32'h0000_0001);
    host.take_mail(which, d, ok);
    chk("first mail", ok ? d : 32'hFFFF_FFFF, 32'hC0DE_0000 + which);
    core_wait(6, took);
    query(c, 3'h0, "refilled");
    host.take_mail(which, d, ok);
    chk("second mail", ok ? d : 32'hFFFF_FFFF, 32'hFEED_0000 + which);
    query(c, 3'h1, "drained");
    chk("read events", ev_cnt - ev0, 2);
    chk("irq count", irq_cnt - irq0, 2 * which);
  endtask

  initial begin
    repeat (10) @(negedge mclk_in);
    reset_n_in = 1'b1;
    t_reset();
    t_inbound();
    t_stall_read();
    t_outbound(0);
    t_outbound(1);
    // second reset in mid-run with a message pending
    host.push(32'h1234_5678);
    do_reset();
    t_reset();
    wrap_up();
  end
endmodule // core_message_mailboxes_test
`default_nettype wire
